// file: design/nfc_pkg.sv
/*
 nfc_pkg: constants shared by the host-side nand command sequencer and its
 pin-cycle engine: register offsets, reset values, command bytes, operation
 codes, step kinds and pin timing counts.
 Assumes a 25 MHz mclk and an asynchronous 8-bit nand die on the far side.
*/
package nfc_pkg;

	localparam int MCLK_NS = 40;

	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + MCLK_NS - 1) / MCLK_NS;
		ns_to_cyc = (c < 1) ? 1 : c;
	endfunction

	// pin timing, minimum times round up
	localparam int T_WP_NS  = 12;
	localparam int T_WH_NS  = 10;
	localparam int T_ADL_NS = 70;
	localparam int T_REA_NS = 25;
	localparam int T_WB_NS  = 100;
	localparam int WP_CYC   = ns_to_cyc(T_WP_NS);
	localparam int HI_CYC   = (ns_to_cyc(T_ADL_NS) > ns_to_cyc(T_WH_NS)) ?
		ns_to_cyc(T_ADL_NS) : ns_to_cyc(T_WH_NS);
	localparam int RE_CYC   = ns_to_cyc(T_REA_NS) + 2;
	localparam int WB_CYC   = ns_to_cyc(T_WB_NS);

	// software register byte offsets
	localparam logic [4:0] REG_CTRL   = 5'h00;
	localparam logic [4:0] REG_COL    = 5'h04;
	localparam logic [4:0] REG_ROW    = 5'h08;
	localparam logic [4:0] REG_DATA   = 5'h0C;
	localparam logic [4:0] REG_PARAM  = 5'h10;
	localparam logic [4:0] REG_STATUS = 5'h14;
	localparam logic [4:0] REG_CFG    = 5'h18;

	// reset values
	localparam logic [15:0] COL_RST   = 16'h0000;
	localparam logic [23:0] ROW_RST   = 24'h00_0000;
	localparam logic [7:0]  DATA_RST  = 8'h00;
	localparam logic [31:0] PARAM_RST = 32'h0000_0000;
	localparam logic        CFG_RST   = 1'b1;

	// row layout: page bits 5:0, plane select bit 6, block bits 16:6
	localparam int PLANE_BIT = 6;

	// nand command bytes
	localparam logic [7:0] C_READ   = 8'h00;
	localparam logic [7:0] C_CBREAD = 8'h35;
	localparam logic [7:0] C_RIN    = 8'h85;
	localparam logic [7:0] C_PROG   = 8'h10;
	localparam logic [7:0] C_ERASE  = 8'h60;
	localparam logic [7:0] C_ECONF  = 8'hD0;
	localparam logic [7:0] C_EQUEUE = 8'hD1;
	localparam logic [7:0] C_RESET  = 8'hFF;
	localparam logic [7:0] C_STAT   = 8'h70;
	localparam logic [7:0] C_STATE  = 8'h78;
	localparam logic [7:0] C_ROUT   = 8'h05;
	localparam logic [7:0] C_ROUTC  = 8'hE0;
	localparam logic [7:0] C_GETF   = 8'hEE;
	localparam logic [7:0] C_SETF   = 8'hEF;

	// feature map
	localparam logic [7:0] FEAT_DRIVE = 8'h80;
	localparam logic [7:0] FEAT_RBPD  = 8'h81;
	localparam logic [7:0] FEAT_MASK  = 8'h03;

	// operation codes written to the control register
	localparam logic [3:0] OP_CB_READ = 4'h1;
	localparam logic [3:0] OP_CB_PROG = 4'h2;
	localparam logic [3:0] OP_ERASE   = 4'h3;
	localparam logic [3:0] OP_EQUEUE  = 4'h4;
	localparam logic [3:0] OP_RESET   = 4'h5;
	localparam logic [3:0] OP_GETF    = 4'h6;
	localparam logic [3:0] OP_SETF    = 4'h7;
	localparam logic [3:0] OP_ROUT    = 4'h8;
	localparam logic [3:0] OP_RIN     = 4'h9;
	localparam logic [3:0] OP_DOUT    = 4'hA;
	localparam logic [3:0] OP_DIN     = 4'hB;
	localparam logic [3:0] OP_STAT    = 4'hC;
	localparam logic [3:0] OP_STATE   = 4'hD;

	typedef enum logic [2:0] {SK_CMD, SK_ADR, SK_DWR, SK_DRD, SK_WAIT, SK_END} nfc_step_type;

endpackage

// file: design/nfc_pin_cycle.sv
/*
 nfc_pin_cycle: drives one nand bus cycle (command, address, data write,
 data read) or one busy wait on the ready/busy line.
 Assumes rb_s and io_s are already synchronised to mclk by the caller.
*/
`timescale 1ns/10ps
`default_nettype none
module nfc_pin_cycle
	import nfc_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// request
	input  wire logic              start,
	input  wire nfc_pkg::nfc_step_type kind,
	input  wire logic [7:0]        wbyte,
	output logic                   done,
	output logic [7:0]             rbyte,
	// synchronised pins
	input  wire logic              rb_s,
	input  wire logic [7:0]        io_s,
	// pin drive
	output logic                   cle,
	output logic                   ale,
	output logic                   we_n,
	output logic                   re_n,
	output logic [7:0]             io_out,
	output logic                   io_oe
);
	typedef enum logic [2:0] {E_IDLE, E_SETUP, E_LOW, E_HIGH, E_SETTLE, E_POLL} nfc_eng_type;

	nfc_eng_type  st_q;
	logic         rd_q;
	logic [3:0]   cnt_q;

	wire cnt_zero = (cnt_q == 4'h0);

	always_ff @(posedge mclk) begin
		done <= 1'b0;
		if (rst) begin
			st_q   <= E_IDLE;
			rd_q   <= 1'b0;
			cnt_q  <= 4'h0;
			rbyte  <= 8'h00;
			cle    <= 1'b0;
			ale    <= 1'b0;
			we_n   <= 1'b1;
			re_n   <= 1'b1;
			io_out <= 8'h00;
			io_oe  <= 1'b0;
		end else begin
			case (st_q)
			E_IDLE: if (start) begin
				// latch and data lines settle a cycle before the strobe falls
				cle    <= (kind == SK_CMD);
				ale    <= (kind == SK_ADR);
				io_oe  <= (kind == SK_CMD) || (kind == SK_ADR) || (kind == SK_DWR);
				io_out <= wbyte;
				rd_q   <= (kind == SK_DRD);
				cnt_q  <= 4'(WB_CYC - 1);
				st_q   <= (kind == SK_WAIT) ? E_SETTLE : E_SETUP;
			end
			E_SETUP: begin
				we_n  <= rd_q;
				re_n  <= !rd_q;
				cnt_q <= rd_q ? 4'(RE_CYC - 1) : 4'(WP_CYC - 1);
				st_q  <= E_LOW;
			end
			E_LOW: if (cnt_zero) begin
				we_n  <= 1'b1;
				re_n  <= 1'b1;
				if (rd_q)
					rbyte <= io_s;
				cnt_q <= 4'(HI_CYC - 1);
				st_q  <= E_HIGH;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
			E_HIGH: if (cnt_zero) begin
				cle   <= 1'b0;
				ale   <= 1'b0;
				io_oe <= 1'b0;
				done  <= 1'b1;
				st_q  <= E_IDLE;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
			// busy may take a while to fall after the last strobe
			E_SETTLE: if (cnt_zero) begin
				st_q <= E_POLL;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
			E_POLL: if (rb_s) begin
				done <= 1'b1;
				st_q <= E_IDLE;
			end
			default: st_q <= E_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: design/nfc_nand_host.sv
/*
 nfc_nand_host: host-side sequencer for copy back, block erase, reset and
 feature access on an asynchronous 8-bit nand die, driven by software over
 Avalon-MM. Assumes one die on the pins, a pulled-up ready/busy line and a
 testbench that resolves the data pins from nand_io_oe.
*/
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - copy-back read sends 00h, five address, 35h
// - copy-back program only within source plane
// - copy-back program sends 85h, five address, 10h
// - erase sends 60h, three row, D0h
// - queued erase started by D0h other plane
// - two-plane erase planes must differ
// - queued erase refuses copy-back program, but not copy-back read
// - EEh reads, EFh writes, one address byte
// - four parameter bytes then busy while storing
module nfc_nand_host (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// nand pins
	output logic             nand_ce_n,
	output logic             nand_cle,
	output logic             nand_ale,
	output logic             nand_we_n,
	output logic             nand_re_n,
	output logic             nand_wp_n,
	output logic      [7:0]  nand_io_out,
	output logic             nand_io_oe,
	input  wire logic [7:0]  nand_io_in,
	input  wire logic        nand_rb_n
);
	import nfc_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_RUN} nfc_state_type;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			be_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	function automatic logic [10:0] mk(input nfc_step_type k, input logic [7:0] v);
		mk = {k, v};
	endfunction

	// sequence tables; address selector 0-1 column, 2-4 row, 5 feature address
	function automatic logic [10:0] step(input logic [3:0] op, input logic [3:0] i);
		step = mk(SK_END, 8'h00);
		case (op)
		OP_CB_READ: case (i)
			4'd0: step = mk(SK_CMD, C_READ);
			4'd1, 4'd2, 4'd3, 4'd4, 4'd5: step = mk(SK_ADR, 8'(i - 4'd1));
			4'd6: step = mk(SK_CMD, C_CBREAD);
			4'd7: step = mk(SK_WAIT, 8'h00);
			default: step = mk(SK_END, 8'h00);
			endcase
		OP_CB_PROG: case (i)
			4'd0: step = mk(SK_CMD, C_RIN);
			4'd1, 4'd2, 4'd3, 4'd4, 4'd5: step = mk(SK_ADR, 8'(i - 4'd1));
			4'd6: step = mk(SK_CMD, C_PROG);
			4'd7: step = mk(SK_WAIT, 8'h00);
			4'd8: step = mk(SK_CMD, C_STAT);
			4'd9: step = mk(SK_DRD, 8'd5);
			default: step = mk(SK_END, 8'h00);
			endcase
		OP_ERASE, OP_EQUEUE: case (i)
			4'd0: step = mk(SK_CMD, C_ERASE);
			4'd1, 4'd2, 4'd3: step = mk(SK_ADR, 8'(i + 4'd1));
			4'd4: step = mk(SK_CMD, (op == OP_ERASE) ? C_ECONF : C_EQUEUE);
			4'd5: step = mk(SK_WAIT, 8'h00);
			4'd6: step = (op == OP_ERASE) ? mk(SK_CMD, C_STAT) : mk(SK_END, 8'h00);
			4'd7: step = (op == OP_ERASE) ? mk(SK_DRD, 8'd5) : mk(SK_END, 8'h00);
			default: step = mk(SK_END, 8'h00);
			endcase
		OP_RESET: case (i)
			4'd0: step = mk(SK_CMD, C_RESET);
			4'd1: step = mk(SK_WAIT, 8'h00);
			4'd2: step = mk(SK_CMD, C_STAT);
			4'd3: step = mk(SK_DRD, 8'd5);
			default: step = mk(SK_END, 8'h00);
			endcase
		OP_GETF, OP_SETF: case (i)
			4'd0: step = mk(SK_CMD, (op == OP_GETF) ? C_GETF : C_SETF);
			4'd1: step = mk(SK_ADR, 8'd5);
			4'd2, 4'd3, 4'd4, 4'd5: step = (op == OP_GETF) ?
				mk(SK_WAIT, 8'h00) : mk(SK_DWR, 8'(i - 4'd1));
			4'd6: step = (op == OP_GETF) ? mk(SK_DRD, 8'd1) : mk(SK_WAIT, 8'h00);
			4'd7, 4'd8, 4'd9: step = (op == OP_GETF) ? mk(SK_DRD, 8'(i - 4'd5)) :
				mk(SK_END, 8'h00);
			default: step = mk(SK_END, 8'h00);
			endcase
		OP_ROUT: case (i)
			4'd0: step = mk(SK_CMD, C_ROUT);
			4'd1, 4'd2: step = mk(SK_ADR, 8'(i - 4'd1));
			4'd3: step = mk(SK_CMD, C_ROUTC);
			default: step = mk(SK_END, 8'h00);
			endcase
		OP_RIN: case (i)
			4'd0: step = mk(SK_CMD, C_RIN);
			4'd1, 4'd2: step = mk(SK_ADR, 8'(i - 4'd1));
			default: step = mk(SK_END, 8'h00);
			endcase
		OP_DOUT: step = (i == 4'd0) ? mk(SK_DRD, 8'd0) : mk(SK_END, 8'h00);
		OP_DIN:  step = (i == 4'd0) ? mk(SK_DWR, 8'd0) : mk(SK_END, 8'h00);
		OP_STAT, OP_STATE: case (i)
			4'd0: step = mk(SK_CMD, (op == OP_STAT) ? C_STAT : C_STATE);
			4'd1, 4'd2, 4'd3: step = (op == OP_STAT) ? mk(SK_DRD, 8'd5) :
				mk(SK_ADR, 8'(i + 4'd1));
			4'd4: step = (op == OP_STAT) ? mk(SK_END, 8'h00) : mk(SK_DRD, 8'd5);
			default: step = mk(SK_END, 8'h00);
			endcase
		default: step = mk(SK_END, 8'h00);
		endcase
	endfunction

	nfc_state_type state_q, state_d;
	logic [3:0]  op_q, idx_q;
	logic [15:0] col_q;
	logic [23:0] row_q;
	logic [7:0]  data_q, stat_q;
	logic [31:0] param_q;
	logic        cfg_wp_q, err_q, queued_q, qplane_q, cb_valid_q, src_plane_q;
	logic        rb_m_q, rb_s_q, rd_ack_q, ce_n_q;
	logic [7:0]  io_m_q, io_s_q;
	logic [31:0] rdata_q;
	logic        eng_done;
	logic [7:0]  eng_rbyte;

	// decode
	wire         busy     = (state_q != ST_IDLE);
	wire         wr_go    = avs_write && !busy;
	wire [3:0]   new_op   = avs_writedata[3:0];
	wire         plane    = row_q[PLANE_BIT];
	wire         bad_cb   = (new_op == OP_CB_PROG) &&
		(!cb_valid_q || plane != src_plane_q || queued_q);
	wire         bad_er   = (new_op == OP_ERASE) && queued_q && (plane == qplane_q);
	wire         bad_op   = (new_op == 4'h0) || (new_op > OP_STATE);
	wire         ctrl_go  = wr_go && (avs_address == REG_CTRL);
	wire         refuse   = ctrl_go && (bad_cb || bad_er || bad_op);
	wire         launch   = ctrl_go && !refuse;
	wire [10:0]  cur      = step(op_q, idx_q);
	wire nfc_step_type cur_k = nfc_step_type'(cur[10:8]);
	wire [7:0]   cur_v    = cur[7:0];
	wire         feat_ok  = (col_q[7:0] == FEAT_DRIVE) || (col_q[7:0] == FEAT_RBPD);
	wire [31:0]  param_tx = feat_ok ? {24'h00_0000, param_q[7:0] & FEAT_MASK} : param_q;
	wire [7:0]   adr_byte = (cur_v == 8'd0) ? col_q[7:0] : (cur_v == 8'd1) ? col_q[15:8] :
		(cur_v == 8'd2) ? row_q[7:0] : (cur_v == 8'd3) ? row_q[15:8] :
		(cur_v == 8'd4) ? row_q[23:16] : col_q[7:0];
	wire [7:0]   dwr_byte = (cur_v == 8'd0) ? data_q : param_tx[{2'(cur_v[1:0] - 2'd1), 3'b000} +: 8];
	wire [7:0]   eng_byte = (cur_k == SK_ADR) ? adr_byte : (cur_k == SK_DWR) ? dwr_byte : cur_v;
	wire         eng_go   = (state_q == ST_ISSUE) && (cur_k != SK_END);
	wire         step_end = (state_q == ST_RUN) && eng_done;
	wire [31:0]  status_w = {16'h0000, stat_q, 3'b000, cb_valid_q, queued_q, err_q, rb_s_q, busy};
	wire [31:0]  rd_mux   = (avs_address == REG_CTRL)   ? {28'h000_0000, op_q} :
		(avs_address == REG_COL)    ? {16'h0000, col_q} :
		(avs_address == REG_ROW)    ? {8'h00, row_q} :
		(avs_address == REG_DATA)   ? {24'h00_0000, data_q} :
		(avs_address == REG_PARAM)  ? param_q :
		(avs_address == REG_STATUS) ? status_w :
		(avs_address == REG_CFG)    ? {31'h0000_0000, cfg_wp_q} : 32'h0000_0000;

	assign avs_waitrequest = (avs_write && busy) || (avs_read && !rd_ack_q);
	assign avs_readdata    = rdata_q;
	assign nand_ce_n       = ce_n_q;
	assign nand_wp_n       = cfg_wp_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
		ST_IDLE:  state_d = launch ? ST_ISSUE : ST_IDLE;
		ST_ISSUE: state_d = (cur_k == SK_END) ? ST_IDLE : ST_RUN;
		ST_RUN:   state_d = eng_done ? ST_ISSUE : ST_RUN;
		default:  state_d = ST_IDLE;
		endcase
	end

	// the pins are asynchronous to mclk
	always_ff @(posedge mclk) begin
		rb_m_q <= nand_rb_n;
		rb_s_q <= rb_m_q;
		io_m_q <= nand_io_in;
		io_s_q <= io_m_q;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q  <= ST_IDLE;
			op_q     <= 4'h0;
			idx_q    <= 4'h0;
			ce_n_q   <= 1'b1;
			rd_ack_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
		end else begin
			state_q  <= state_d;
			ce_n_q   <= (state_d == ST_IDLE);
			rd_ack_q <= avs_read && !rd_ack_q;
			rdata_q  <= rd_mux;
			if (launch) begin
				op_q  <= new_op;
				idx_q <= 4'h0;
			end else if (step_end) begin
				idx_q <= idx_q + 4'h1;
			end
		end
	end

	// software registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			col_q    <= COL_RST;
			row_q    <= ROW_RST;
			cfg_wp_q <= CFG_RST;
			err_q    <= 1'b0;
		end else begin
			if (wr_go && avs_address == REG_COL)
				col_q <= 16'(be_merge({16'h0000, col_q}, avs_writedata, avs_byteenable));
			if (wr_go && avs_address == REG_ROW)
				row_q <= 24'(be_merge({8'h00, row_q}, avs_writedata, avs_byteenable));
			if (wr_go && avs_address == REG_CFG && avs_byteenable[0])
				cfg_wp_q <= avs_writedata[0];
			if (ctrl_go)
				err_q <= refuse;
		end
	end

	// data, parameters and status byte from the pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_q  <= DATA_RST;
			param_q <= PARAM_RST;
			stat_q  <= 8'h00;
		end else if (step_end && cur_k == SK_DRD) begin
			if (cur_v == 8'd0)
				data_q <= eng_rbyte;
			else if (cur_v == 8'd5)
				stat_q <= eng_rbyte;
			else
				param_q[{2'(cur_v[1:0] - 2'd1), 3'b000} +: 8] <= eng_rbyte;
		end else begin
			if (wr_go && avs_address == REG_DATA && avs_byteenable[0])
				data_q <= avs_writedata[7:0];
			if (wr_go && avs_address == REG_PARAM)
				param_q <= be_merge(param_q, avs_writedata, avs_byteenable);
		end
	end

	// plane bookkeeping follows the commands actually sent
	always_ff @(posedge mclk) begin
		if (rst) begin
			queued_q    <= 1'b0;
			qplane_q    <= 1'b0;
			cb_valid_q  <= 1'b0;
			src_plane_q <= 1'b0;
		end else if (step_end && cur_k == SK_CMD) begin
			if (cur_v == C_EQUEUE) begin
				queued_q <= 1'b1;
				qplane_q <= plane;
			end
			if (cur_v == C_ECONF || cur_v == C_RESET)
				queued_q <= 1'b0;
			if (cur_v == C_CBREAD) begin
				cb_valid_q  <= 1'b1;
				src_plane_q <= plane;
			end
			if (cur_v == C_RESET || cur_v == C_ERASE)
				cb_valid_q <= 1'b0;
		end
	end

	nfc_pin_cycle u_cycle (
		.mclk   (mclk),
		.rst    (rst),
		.start  (eng_go),
		.kind   (cur_k),
		.wbyte  (eng_byte),
		.done   (eng_done),
		.rbyte  (eng_rbyte),
		.rb_s   (rb_s_q),
		.io_s   (io_s_q),
		.cle    (nand_cle),
		.ale    (nand_ale),
		.we_n   (nand_we_n),
		.re_n   (nand_re_n),
		.io_out (nand_io_out),
		.io_oe  (nand_io_oe)
	);

	default clocking cb_main @(posedge mclk); endclocking
	default disable iff (rst);

	AST_CB_PLANE: assert property (launch && new_op == OP_CB_PROG |-> plane == src_plane_q)
		else $error("copy back launched across planes");
	AST_NO_MIX: assert property (launch && new_op == OP_CB_PROG |-> !queued_q)
		else $error("copy back launched over a queued erase");
	AST_ERASE_PLANE: assert property (launch && new_op == OP_ERASE && queued_q |->
		plane != qplane_q)
		else $error("two-plane erase with equal planes");
	AST_QUEUE_DONE: assert property (step_end && cur_k == SK_CMD && cur_v == C_ECONF |=>
		!queued_q)
		else $error("queue flag outlived the erase confirm");
	AST_WAIT_READY: assert property (state_q == ST_RUN && cur_k == SK_WAIT && eng_done |->
		rb_s_q)
		else $error("wait step ended while busy");
	AST_STROBES: assert property (!(!nand_we_n && !nand_re_n) && !(nand_cle && nand_ale))
		else $error("strobes or latches overlap");
	AST_CMD_SETUP: assert property ($fell(nand_we_n) |-> $past(nand_cle) == nand_cle &&
		$past(nand_ale) == nand_ale && nand_io_oe && !nand_ce_n)
		else $error("write strobe without stable setup");
	AST_FEAT_PARAMS: assert property (launch && new_op == OP_SETF |=> ##[1:200]
		(state_q == ST_RUN && cur_k == SK_DWR && idx_q == 4'd5))
		else $error("fourth feature byte never sent");
	AST_RESET_INVAL: assert property (step_end && cur_k == SK_CMD && cur_v == C_RESET |=>
		!cb_valid_q && !queued_q)
		else $error("reset left cache or queue marked valid");

	COV_CB_PROG: cover property (launch && new_op == OP_CB_PROG);
	COV_QUEUE: cover property (step_end && cur_k == SK_CMD && cur_v == C_EQUEUE);
	COV_GETF_END: cover property (step_end && op_q == OP_GETF && idx_q == 4'd9);
	COV_REFUSE: cover property (refuse);
endmodule
`default_nettype wire

// file: sim/nfc_nand_model.sv
/*
 nfc_nand_model: behavioural 8-bit nand die facing the host pins.
 Assumes the bench resolves io and sets the busy length in mclk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module nfc_nand_model (
	// host pins
	input  wire logic       mclk,
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] io,
	input  wire logic [7:0] bsy_len,
	// die answers
	output logic      [7:0] dq,
	output logic            rb_n
);
	logic [7:0] cache [0:2111]; // one page of 2112 bytes
	logic [7:0] ad [0:4];
	logic [7:0] par [0:3];
	logic [7:0] cmd = 8'h00;
	logic [7:0] fa = 8'h00;
	logic [1:0] drv_q = 2'h0; // output_drive_strength_feature, reset 00h
	logic [1:0] pd_q = 2'h0;
	int na = 0, np = 0, col = 0, cyc = 0, bend = 0;
	wire logic rdy = (cyc >= bend);
	wire logic [7:0] st = {wp_n, rdy, rdy, 5'h00}; // bit 6 ready, bit 5 array idle
	assign rb_n = rdy;
	initial dq = 8'h00;
	always @(posedge mclk) cyc <= cyc + 1;
	always @(posedge we_n) begin
		if (!ce_n && cle) begin
			cmd = io;
			na = 0;
			np = 0;
			case (io)
			8'h35: begin // source page into cache, output from given column
				col = {ad[1], ad[0]};
				for (int i = 0; i < 2112; i++) cache[i] = i[7:0] ^ ad[2];
				bend = cyc + bsy_len;
			end
			// program keeps merged cache; erase acts on the block
			8'h10, 8'hD0: bend = cyc + bsy_len;
			8'hD1: bend = cyc + 3; // short queue busy
			8'hE0: col = {ad[1], ad[0]}; // reposition output
			8'hFF: begin // abort, cache invalid, features kept
				for (int i = 0; i < 2112; i++) cache[i] = 8'hFF;
				bend = cyc + bsy_len;
			end
			default: ;
			endcase
		end else if (!ce_n && ale) begin
			if (na < 5) ad[na] = io;
			na++;
			if (cmd == 8'h85 && na == 2) col = {io, ad[0]};
			if (cmd == 8'hEE || cmd == 8'hEF) fa = io; // one address byte
			if (cmd == 8'hEE) begin // reserved entries read zero
				par = '{8'h00, 8'h00, 8'h00, 8'h00};
				if (io == 8'h80) par[0] = {6'h00, drv_q};
				if (io == 8'h81) par[0] = {6'h00, pd_q};
				bend = cyc + 3;
			end
		end else if (!ce_n) begin
			if (cmd == 8'h85) begin // random input merges into cache
				cache[col % 2112] = io;
				col++;
			end
			if (cmd == 8'hEF) begin // one parameter per rising strobe
				if (np == 0 && fa == 8'h80) drv_q = io[1:0]; // bits 1:0 only
				if (np == 0 && fa == 8'h81) pd_q = io[1:0];
				np++;
				if (np == 4) bend = cyc + 3;
			end
		end
	end
	always @(negedge re_n) begin
		if (!ce_n) begin
			if (cmd == 8'h70 || cmd == 8'h78) dq = st; // bit 0 pass
			else if (cmd == 8'hEE) begin
				dq = par[np % 4];
				np++;
			end else begin
				dq = cache[col % 2112]; // sequential output
				col++;
			end
		end
	end
	// released bus must not keep showing the last byte
	always @(posedge re_n) dq = ~dq;
endmodule
`default_nettype wire

// file: sim/nfc_nand_host_bench.sv
/*
 nfc_nand_host_bench: drives the sequencer over avalon-mm against the
 behavioural die. Assumes nfc_pkg and both modules are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module nfc_nand_host_bench;
	import nfc_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata, q, seed = 32'he0f7;
	logic        avs_waitrequest, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
	logic [7:0]  io_out, dq, io, b, bsy_len = 8'h05;
	logic [15:0] c;
	logic [23:0] r;
	int          n_mismatch = 0, checked = 0, cyc = 0;
	logic [3:0]  bad_ops [0:2] = '{4'h0, 4'hE, 4'hF};
	assign io = oe ? io_out : dq;
	nfc_nand_host u_nfc_nand_host (.mclk(mclk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .nand_ce_n(ce_n), .nand_cle(cle),
		.nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n), .nand_wp_n(wp_n),
		.nand_io_out(io_out), .nand_io_oe(oe), .nand_io_in(io), .nand_rb_n(rb_n));
	nfc_nand_model u_nfc_nand_model (.mclk(mclk), .ce_n(ce_n), .cle(cle), .ale(ale),
		.we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io(io), .bsy_len(bsy_len), .dq(dq),
		.rb_n(rb_n));
	initial forever #20 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] exp_b(input logic [23:0] rr, input logic [15:0] cc);
		return {24'h00_0000, cc[7:0] ^ rr[7:0]};
	endfunction
	task automatic final_report();
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic op(input logic [3:0] o);
		bus(1'b1, REG_CTRL, {28'h000_0000, o});
		do bus(1'b0, REG_STATUS, 32'h0000_0000); while (q[0] !== 1'b0);
	endtask
	task automatic rc(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	task automatic st(input logic [7:0] sb, input logic [1:0] eq);
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		chk({22'h00_0000, q[15:8], q[3:2]}, {22'h00_0000, sb, eq});
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rc(REG_COL, {16'h0000, COL_RST});
		rc(REG_ROW, {8'h00, ROW_RST});
		rc(REG_PARAM, PARAM_RST);
		rc(REG_CFG, {31'h0000_0000, CFG_RST});
		rc(5'h1C, 32'h0000_0000);
		bus(1'b1, REG_COL, 32'h0000_0080);
		op(OP_GETF);
		rc(REG_PARAM, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			b = 8'(rnd());
			bsy_len <= {3'h0, b[4:0]} + 8'h03;
			c = 16'(rnd() % 2000);
			r = 24'(rnd());
			bus(1'b1, REG_COL, {16'h0000, c});
			bus(1'b1, REG_ROW, {8'h00, r});
			op(OP_CB_READ);
			for (int i = 0; i < 3; i++) begin
				op(OP_DOUT);
				rc(REG_DATA, exp_b(r, c + 16'(i)));
			end
			bus(1'b1, REG_COL, {16'h0000, c + 16'h0064});
			op(OP_ROUT);
			op(OP_DOUT);
			rc(REG_DATA, exp_b(r, c + 16'h0064));
			b = 8'(rnd());
			op(OP_RIN);
			bus(1'b1, REG_DATA, {24'h00_0000, b});
			op(OP_DIN);
			op(OP_ROUT);
			op(OP_DOUT);
			rc(REG_DATA, {24'h00_0000, b});
			// refresh the status byte so the refusal check sees a known value
			op(OP_STAT);
			bus(1'b1, REG_ROW, {8'h00, r ^ 24'h00_0040});
			bus(1'b1, REG_CTRL, {28'h000_0000, OP_CB_PROG});
			st(8'hE0, 2'b01);
			bus(1'b1, REG_ROW, {8'h00, r ^ 24'h00_0100});
			op(OP_CB_PROG);
			st(8'hE0, 2'b00);
			op(OP_ERASE);
			st(8'hE0, 2'b00);
			op(OP_EQUEUE);
			st(8'hE0, 2'b10);
			bus(1'b1, REG_CTRL, {28'h000_0000, OP_ERASE});
			st(8'hE0, 2'b11);
			bus(1'b1, REG_ROW, {8'h00, r ^ 24'h00_0040});
			op(OP_ERASE);
			st(8'hE0, 2'b00);
			op(OP_STATE);
			st(8'hE0, 2'b00);
			b = 8'(rnd());
			bus(1'b1, REG_PARAM, {24'h00_0000, b});
			bus(1'b1, REG_COL, {24'h00_0000, 7'h40, k[0]});
			op(OP_SETF);
			op(OP_GETF);
			rc(REG_PARAM, {30'h0000_0000, b[1:0]});
			bus(1'b1, REG_COL, {24'h00_0000, b | 8'h02});
			if (b[7:1] != 7'h40) begin
				op(OP_SETF);
				op(OP_GETF);
				rc(REG_PARAM, 32'h0000_0000);
			end
			bus(1'b1, REG_CFG, {31'h0000_0000, k[1]});
			op(OP_RESET);
			st(k[1] ? 8'hE0 : 8'h60, 2'b00);
			bus(1'b1, REG_COL, {24'h00_0000, 7'h40, k[0]});
			op(OP_GETF);
			rc(REG_PARAM, {30'h0000_0000, b[1:0]});
			bus(1'b1, REG_CFG, 32'h0000_0001);
		end
		foreach (bad_ops[i]) begin
			bus(1'b1, REG_CTRL, {28'h000_0000, bad_ops[i]});
			st(8'hE0, 2'b01);
		end
		final_report();
	end
endmodule
`default_nettype wire
